// ==== inc/kr4c_pkg.sv ====
// Package with register map, field positions and reset values of the training override registers
package kr4c_pkg;
  localparam int          KR4C_LANES          = 4;
  localparam int          KR4C_AW             = 12;
  // Printed offsets are register indices; byte address is four times the index
  localparam logic [9:0]  KR4C_IDX_AN_CTRL    = 10'h0c0;
  localparam logic [9:0]  KR4C_IDX_MASTER_SEL = 10'h0cc;
  localparam logic [9:0]  KR4C_IDX_COEF_OVR   = 10'h0d0;
  localparam logic [9:0]  KR4C_IDX_LANE_CTRL  = 10'h0d1;
  localparam int          KR4C_MLO_EN_BIT     = 6;
  localparam int          KR4C_PCO_EN_BIT     = 16;
  localparam int          KR4C_LCO_EN_BIT     = 17;
  localparam int          KR4C_RESTART_LSB    = 0;
  localparam int          KR4C_PNEW_LSB       = 4;
  localparam int          KR4C_LNEW_LSB       = 8;
  localparam int          KR4C_PCMD_W         = 6;
  localparam int          KR4C_LCOEF_W        = 8;
  localparam logic [3:0]  KR4C_MASTER_SEL_RST = 4'h0;
  localparam logic [3:0]  KR4C_AN_MASTER_DEF  = 4'h1;
  localparam logic [31:0] KR4C_ZERO_WORD      = 32'h0000_0000;
endpackage : kr4c_pkg

// ==== inc/kr4c_req_if.sv ====
// Interface carrying one kind of per-lane self-clearing request
`timescale 1ns/1ps
interface kr4c_req_if;
  logic [3:0] set;   // Accepted write of 1 per lane
  logic [3:0] ack;   // Training logic has taken the request
  logic [3:0] pend;  // Request still outstanding
  modport owner (input set, input ack, output pend);
  modport user  (output set, output ack, input pend);
endinterface : kr4c_req_if

// ==== core/kr4c_sc_req.sv ====
// Per-lane self-clearing request bits held until the training logic accepts them
`timescale 1ns/1ps
module kr4c_sc_req
(
  input wire logic    pclk,    // Bus clock
  input wire logic    presetn, // Async reset, active low
  kr4c_req_if.owner   req      // Set, accept and pending bits
);
  logic [3:0] pend_reg;
  logic [3:0] pend_next;

  // A new write in the accept cycle survives: set wins over clear
  always_comb
  begin
    pend_next = (pend_reg & ~req.ack) | req.set;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pend_reg <= 4'h0;
    else
      pend_reg <= pend_next;
  end

  assign req.pend = pend_reg;

  AST_SC_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
    (req.ack[0] && !req.set[0]) |=> !pend_reg[0])
    else $error("Accepted request bit did not self-clear");
endmodule : kr4c_sc_req

// ==== core/kr4c_ctrl.sv ====
// APB register bank for master-lane and coefficient override control of a four-lane backplane link
`timescale 1ns/1ps
module kr4c_ctrl
  import kr4c_pkg::*;
#(
  parameter logic [3:0] AN_MASTER_LANE = KR4C_AN_MASTER_DEF // Negotiation master parameter, one-hot
)
(
  input  wire logic              pclk,            // Bus clock, 40 MHz
  input  wire logic              presetn,         // Async reset, active low
  input  wire logic              psel,            // APB select
  input  wire logic              penable,         // APB access phase
  input  wire logic              pwrite,          // APB write
  input  wire logic [KR4C_AW-1:0] paddr,          // APB byte address
  input  wire logic [31:0]       pwdata,          // APB write data
  output logic      [31:0]       prdata,          // APB read data
  output logic                   pready,          // APB ready
  output logic                   pslverr,         // APB error on unmapped address
  output logic      [3:0]        an_master_lane,  // Negotiation master lane: KR4C_AN_MASTER_DEF in reset, then one-hot parameter value, or select field as written under override
  output logic                   partner_coef_override_en, // Partner override enable
  output logic                   local_coef_override_en,   // Local override enable
  output logic      [3:0]        restart_req,     // Per-lane training restart request
  output logic      [3:0]        partner_new_req, // Per-lane send programmed partner update
  output logic      [3:0]        local_new_req,   // Per-lane apply programmed local coefficients
  input  wire logic [3:0]        restart_ack,     // Training logic took restart
  input  wire logic [3:0]        partner_new_ack, // Training logic took partner update
  input  wire logic [3:0]        local_new_ack,   // Training logic took local coefficients
  input  wire logic [23:0]       tl_partner_cmd,  // Training logic partner commands, 6 bits per lane
  input  wire logic [23:0]       sw_partner_cmd,  // Software partner commands, 6 bits per lane
  input  wire logic [31:0]       rx_local_coef,   // Coefficients derived from partner updates
  input  wire logic [31:0]       sw_local_coef,   // Software local coefficients, 8 bits per lane
  output logic      [23:0]       partner_cmd,     // Commands sent to the partner equalizer
  output logic      [31:0]       local_coef       // Local transmit equalizer coefficients
);
  localparam logic [KR4C_AW-1:0] ADDR_AN_CTRL    = {KR4C_IDX_AN_CTRL, 2'b00};
  localparam logic [KR4C_AW-1:0] ADDR_MASTER_SEL = {KR4C_IDX_MASTER_SEL, 2'b00};
  localparam logic [KR4C_AW-1:0] ADDR_COEF_OVR   = {KR4C_IDX_COEF_OVR, 2'b00};
  localparam logic [KR4C_AW-1:0] ADDR_LANE_CTRL  = {KR4C_IDX_LANE_CTRL, 2'b00};

  kr4c_req_if rst_if ();
  kr4c_req_if pnew_if ();
  kr4c_req_if lnew_if ();

  logic        mlo_en_reg,  mlo_en_next;
  logic [3:0]  msel_reg,    msel_next;
  logic        pco_en_reg,  pco_en_next;
  logic        lco_en_reg,  lco_en_next;
  logic [31:0] prdata_reg,  prdata_next;
  logic        pready_reg,  pready_next;
  logic        pslverr_reg, pslverr_next;
  logic [3:0]  master_reg,  master_next;
  logic [23:0] pcmd_reg,    pcmd_next;
  logic [31:0] lcoef_reg,   lcoef_next;
  logic        setup;
  logic        wr_done;
  logic        mapped;

  assign setup   = psel && !penable;
  assign wr_done = psel && penable && pready_reg && pwrite;
  assign mapped  = (paddr == ADDR_AN_CTRL) || (paddr == ADDR_MASTER_SEL) ||
                   (paddr == ADDR_COEF_OVR) || (paddr == ADDR_LANE_CTRL);

  // Register bank and APB answer; ready comes one cycle after setup, so no wait states
  always_comb
  begin
    mlo_en_next  = mlo_en_reg;
    msel_next    = msel_reg;
    pco_en_next  = pco_en_reg;
    lco_en_next  = lco_en_reg;
    prdata_next  = prdata_reg;
    pready_next  = setup;
    pslverr_next = setup && !mapped;
    rst_if.set   = 4'h0;
    pnew_if.set  = 4'h0;
    lnew_if.set  = 4'h0;
    if (setup && !pwrite)
    begin
      prdata_next = KR4C_ZERO_WORD;
      if (paddr == ADDR_AN_CTRL)
        prdata_next[KR4C_MLO_EN_BIT] = mlo_en_reg;
      else if (paddr == ADDR_MASTER_SEL)
        prdata_next[3:0] = msel_reg;
      else if (paddr == ADDR_COEF_OVR)
      begin
        prdata_next[KR4C_PCO_EN_BIT] = pco_en_reg;
        prdata_next[KR4C_LCO_EN_BIT] = lco_en_reg;
      end
      else if (paddr == ADDR_LANE_CTRL)
      begin
        prdata_next[KR4C_RESTART_LSB +: 4] = rst_if.pend;
        prdata_next[KR4C_PNEW_LSB +: 4]    = pnew_if.pend;
        prdata_next[KR4C_LNEW_LSB +: 4]    = lnew_if.pend;
      end
    end
    if (wr_done)
    begin
      if (paddr == ADDR_AN_CTRL)
        mlo_en_next = pwdata[KR4C_MLO_EN_BIT];
      else if (paddr == ADDR_MASTER_SEL)
        msel_next = pwdata[3:0];
      else if (paddr == ADDR_COEF_OVR)
      begin
        pco_en_next = pwdata[KR4C_PCO_EN_BIT];
        lco_en_next = pwdata[KR4C_LCO_EN_BIT];
      end
      else if (paddr == ADDR_LANE_CTRL)
      begin
        rst_if.set = pwdata[KR4C_RESTART_LSB +: 4];
        // Gated by the enable as it stands before this write
        pnew_if.set = pco_en_reg ? pwdata[KR4C_PNEW_LSB +: 4] : 4'h0;
        lnew_if.set = lco_en_reg ? pwdata[KR4C_LNEW_LSB +: 4] : 4'h0;
      end
    end
  end

  // Master lane and coefficient paths
  always_comb
  begin
    master_next = mlo_en_reg ? msel_reg : AN_MASTER_LANE;
    pcmd_next   = pco_en_reg ? sw_partner_cmd : tl_partner_cmd;
    lcoef_next  = lco_en_reg ? sw_local_coef : rx_local_coef;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mlo_en_reg  <= 1'b0;
      msel_reg    <= KR4C_MASTER_SEL_RST;
      pco_en_reg  <= 1'b0;
      lco_en_reg  <= 1'b0;
      prdata_reg  <= KR4C_ZERO_WORD;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      master_reg  <= KR4C_AN_MASTER_DEF;
      pcmd_reg    <= 24'h00_0000;
      lcoef_reg   <= KR4C_ZERO_WORD;
    end
    else
    begin
      mlo_en_reg  <= mlo_en_next;
      msel_reg    <= msel_next;
      pco_en_reg  <= pco_en_next;
      lco_en_reg  <= lco_en_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      master_reg  <= master_next;
      pcmd_reg    <= pcmd_next;
      lcoef_reg   <= lcoef_next;
    end
  end

  assign rst_if.ack  = restart_ack;
  assign pnew_if.ack = partner_new_ack;
  assign lnew_if.ack = local_new_ack;

  kr4c_sc_req u_restart (.pclk(pclk), .presetn(presetn), .req(rst_if));
  kr4c_sc_req u_pnew    (.pclk(pclk), .presetn(presetn), .req(pnew_if));
  kr4c_sc_req u_lnew    (.pclk(pclk), .presetn(presetn), .req(lnew_if));

  assign prdata                   = prdata_reg;
  assign pready                   = pready_reg;
  assign pslverr                  = pslverr_reg;
  assign an_master_lane           = master_reg;
  assign partner_coef_override_en = pco_en_reg;
  assign local_coef_override_en   = lco_en_reg;
  assign restart_req              = rst_if.pend;
  assign partner_new_req          = pnew_if.pend;
  assign local_new_req            = lnew_if.pend;
  assign partner_cmd              = pcmd_reg;
  assign local_coef               = lcoef_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_lane_write;
    wr_done && (paddr == ADDR_LANE_CTRL);
  endsequence

  // Path checks start only once reset is sampled high, since the mux outputs lag their selects by one edge
  AST_MASTER_OVERRIDE: assert property (mlo_en_reg ##1 $stable(msel_reg)
    |-> an_master_lane == $past(msel_reg))
    else $error("Master lane not taken from select field");
  AST_MASTER_PARAM: assert property (presetn && !mlo_en_reg |=> an_master_lane == AN_MASTER_LANE)
    else $error("Master lane not taken from parameter");
  AST_PARTNER_PATH: assert property (presetn && pco_en_reg && $stable(sw_partner_cmd)
    |=> partner_cmd == sw_partner_cmd)
    else $error("Partner commands not from software under override");
  AST_LOCAL_PATH: assert property (presetn && !lco_en_reg && $stable(rx_local_coef)
    |=> local_coef == rx_local_coef)
    else $error("Local coefficients not derived from partner updates");
  AST_RESTART_SET: assert property ((s_lane_write and pwdata[KR4C_RESTART_LSB]) |=> restart_req[0])
    else $error("Restart write did not raise request");
  AST_PNEW_SET: assert property ((s_lane_write and (pco_en_reg && pwdata[KR4C_PNEW_LSB + 1]))
    |=> partner_new_req[1])
    else $error("Partner new write did not raise request");
  AST_PNEW_BLOCK: assert property ((s_lane_write and (!pco_en_reg && !partner_new_req[2]))
    |=> !partner_new_req[2])
    else $error("Partner new accepted while override clear");
  AST_LNEW_SET: assert property ((s_lane_write and (lco_en_reg && pwdata[KR4C_LNEW_LSB + 3]))
    |=> local_new_req[3])
    else $error("Local new write did not raise request");
  AST_LNEW_BLOCK: assert property ((s_lane_write and (!lco_en_reg && !local_new_req[0]))
    |=> !local_new_req[0])
    else $error("Local new accepted while override clear");
  AST_READY_ONE: assert property (setup |=> pready ##1 !pready)
    else $error("Ready not a single cycle after setup");
endmodule : kr4c_ctrl

// ==== dv/kr4c_tl_model.sv ====
// Training logic model that accepts the self-clearing requests after a set delay
`timescale 1ns/1ps
module kr4c_tl_model
(
  input  wire logic       pclk,    // Bus clock
  input  wire logic       presetn, // Async reset, active low
  input  wire logic [3:0] dly,     // Cycles before acceptance, 0 is prompt
  input  wire logic [3:0] rst_req, // Restart requests
  input  wire logic [3:0] pn_req,  // Partner update requests
  input  wire logic [3:0] ln_req,  // Local update requests
  output logic      [3:0] rst_ack, // Restart accepted
  output logic      [3:0] pn_ack,  // Partner update accepted
  output logic      [3:0] ln_ack   // Local update accepted
);
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic       busy;
  logic       go;
  assign busy = |{rst_req, pn_req, ln_req};
  assign go   = busy && (cnt_reg == dly);
  always_comb
  begin
    cnt_next = (busy && !go) ? cnt_reg + 4'h1 : 4'h0;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_reg <= 4'h0;
    else
      cnt_reg <= cnt_next;
  end
  // All pending kinds are taken together; keeps the model small
  assign rst_ack = rst_req & {4{go}};
  assign pn_ack  = pn_req & {4{go}};
  assign ln_ack  = ln_req & {4{go}};
endmodule : kr4c_tl_model

// ==== dv/kr4_training_override_ctrl_bench.sv ====
// Self-checking testbench for the training override register bank
`timescale 1ns/1ps
module kr4_training_override_ctrl_bench;
  import kr4c_pkg::*;
  localparam logic [3:0]  MPAR   = 4'h4;
  localparam logic [23:0] TL_CMD = 24'h15a5a5;
  localparam logic [23:0] SW_CMD = 24'h2a5a5a;
  localparam logic [31:0] RX_CF  = 32'h11223344;
  localparam logic [31:0] SW_CF  = 32'h55667788;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, pco, lco, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, lcoef;
  logic [3:0]  mlane, rreq, preq, lreq, rack, pack, lack, dly;
  logic [23:0] pcmd;
  int          err_total, checks_done, n;
  kr4c_ctrl #(.AN_MASTER_LANE(MPAR)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .an_master_lane(mlane), .partner_coef_override_en(pco), .local_coef_override_en(lco),
    .restart_req(rreq), .partner_new_req(preq), .local_new_req(lreq), .restart_ack(rack),
    .partner_new_ack(pack), .local_new_ack(lack), .tl_partner_cmd(TL_CMD), .sw_partner_cmd(SW_CMD),
    .rx_local_coef(RX_CF), .sw_local_coef(SW_CF), .partner_cmd(pcmd), .local_coef(lcoef));
  kr4c_tl_model tl (.pclk(pclk), .presetn(presetn), .dly(dly), .rst_req(rreq), .pn_req(preq),
    .ln_req(lreq), .rst_ack(rack), .pn_ack(pack), .ln_ack(lack));
  task automatic give_verdict();
    if (err_total == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One APB transfer; holds the request until pready is seen high or 20 cycles have passed
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    // A slave that never answers counts as a mismatch
    if (pready !== 1'b1)
      err_total++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic settle();
    repeat (3) @(negedge pclk);
  endtask : settle
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    err_total++;
    give_verdict();
  end
  initial
  begin
    err_total = 0;
    checks_done = 0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    dly = 4'h5;
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    chk(32'(mlane), 32'(MPAR));
    chk(32'(pcmd), 32'(TL_CMD));
    chk(lcoef, RX_CF);
    apb(1'b0, KR4C_IDX_MASTER_SEL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, KR4C_IDX_AN_CTRL, 32'h40);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, KR4C_IDX_MASTER_SEL, 32'h1 << i);
      settle();
      chk(32'(mlane), 32'h1 << i);
      apb(1'b0, KR4C_IDX_MASTER_SEL, 32'h0);
      chk(rd, 32'h1 << i);
    end
    apb(1'b1, KR4C_IDX_AN_CTRL, 32'h0);
    settle();
    chk(32'(mlane), 32'(MPAR));
    // New-value bits while both overrides are off must do nothing
    apb(1'b1, KR4C_IDX_LANE_CTRL, 32'hff0);
    @(negedge pclk);
    chk(32'(preq), 32'h0);
    chk(32'(lreq), 32'h0);
    apb(1'b0, KR4C_IDX_LANE_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, KR4C_IDX_COEF_OVR, 32'h1_0000);
    settle();
    chk(32'(pcmd), 32'(SW_CMD));
    chk(lcoef, RX_CF);
    apb(1'b1, KR4C_IDX_COEF_OVR, 32'h3_0000);
    settle();
    chk(lcoef, SW_CF);
    chk(32'({pco, lco}), 32'h3);
    apb(1'b0, KR4C_IDX_COEF_OVR, 32'h0);
    chk(rd, 32'h3_0000);
    // Slow acceptance: bits stay pending, then clear
    apb(1'b1, KR4C_IDX_LANE_CTRL, 32'hfff);
    @(negedge pclk);
    chk(32'(rreq), 32'hf);
    chk(32'(preq), 32'hf);
    chk(32'(lreq), 32'hf);
    apb(1'b0, KR4C_IDX_LANE_CTRL, 32'h0);
    chk(rd, 32'hfff);
    for (n = 0; n < 50 && (rreq | preq | lreq) !== 4'h0; n++)
      @(negedge pclk);
    chk(32'({rreq, preq, lreq}), 32'h0);
    apb(1'b0, KR4C_IDX_LANE_CTRL, 32'h0);
    chk(rd, 32'h0);
    dly <= 4'h0;
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, KR4C_IDX_LANE_CTRL, 32'h111 << i);
      @(negedge pclk);
      chk(32'({rreq, preq, lreq}), 32'h111 << i);
      @(negedge pclk);
      chk(32'({rreq, preq, lreq}), 32'h0);
    end
    apb(1'b1, 10'h3ff, 32'hffff_ffff);
    chk(32'(err), 32'h1);
    apb(1'b0, 10'h3ff, 32'h0);
    chk(rd, 32'h0);
    chk(32'(err), 32'h1);
    apb(1'b0, KR4C_IDX_MASTER_SEL, 32'h0);
    chk(rd, 32'h8);
    // Reset in mid-run brings every register back to its reset value
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    chk(32'(mlane), 32'(MPAR));
    chk(lcoef, RX_CF);
    chk(32'(pcmd), 32'(TL_CMD));
    apb(1'b0, KR4C_IDX_MASTER_SEL, 32'h0);
    chk(rd, 32'(KR4C_MASTER_SEL_RST));
    apb(1'b0, KR4C_IDX_COEF_OVR, 32'h0);
    chk(rd, KR4C_ZERO_WORD);
    give_verdict();
  end
endmodule : kr4_training_override_ctrl_bench
